// File: logic/pas_seq.sv
// Pump start sequencer: cleaning pulses, lubrication output, flow check
`default_nettype none

module pas_seq import pas_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic run_req, // Run request pin
    input wire logic derag_din, // Cleaning trigger pin
    input wire logic flow_ok, // Flow confirmation pin
    input wire logic high_power, // High power flag, same clock
    input wire logic motor_stopped, // Motor at standstill, same clock
    output logic motor_run, // Ramp motor up and hold speed
    output logic motor_rev, // Run in reverse
    output logic motor_coast, // Release the motor output
    output logic lube_out, // Lubrication device request
    output logic derag_dout, // Cleaning active on digital output
    output logic derag_active, // Cleaning event active
    output logic flow_verifying, // Flow check status for operator_panel
    output logic no_flow_trip, // Trip on missing flow
    output logic [7:0] alarm_code // Alarm number while tripped
);

    typedef struct packed {
        // Settings
        logic [1:0] lube_mode;
        logic dg_en;
        logic flow_en;
        logic [2:0] src;
        logic dout_dg;
        logic [7:0] dg_cycles;
        pas_tmr_t dg_run;
        pas_tmr_t dg_off;
        pas_tmr_t start_dly;
        pas_tmr_t pre_lube;
        pas_tmr_t post_lube;
        pas_tmr_t valid_t;
        pas_tmr_t verify_t;
        // Pin synchronisers and edge history
        logic run_m;
        logic run_s;
        logic run_d;
        logic din_m;
        logic din_s;
        logic din_d;
        logic flow_m;
        logic flow_s;
        logic pwr_d;
        // Sequencer
        pas_state_e state;
        pas_tmr_t cnt;
        logic dg_fwd;
        logic [7:0] dg_left;
        pas_flow_e fl;
        pas_tmr_t fcnt;
        logic lube;
        logic post;
        pas_tmr_t lcnt;
        logic trip;
        logic [7:0] alarm;
        // Outputs
        logic m_run;
        logic m_rev;
        logic m_coast;
        logic dg_act;
        logic dg_dout;
        logic fl_ver;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } pas_seq_s;

    pas_seq_s s;
    pas_seq_s next_s;
    logic tick;

    pas_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick(tick)
    );

    // Pin edges are taken from the second synchroniser stage; the power edge comes from the raw high_power flag
    logic run_rise;
    logic run_fall;
    logic din_rise;
    logic pwr_rise;
    logic setup;
    logic wr;
    logic slc_trig;
    logic timed_trig;
    logic dg_trig;
    logic [31:0] status;
    logic mapped;

    assign run_rise = s.run_s & ~s.run_d;
    assign run_fall = ~s.run_s & s.run_d;
    assign din_rise = s.din_s & ~s.din_d;
    assign pwr_rise = high_power & ~s.pwr_d;
    assign setup = psel & ~penable;
    assign wr = psel & penable & s.rdy & pwrite;
    assign slc_trig = wr & (paddr == REG_CTRL) & pwdata[CTRL_SLC_TRIG];
    assign timed_trig = wr & (paddr == REG_CTRL) & pwdata[CTRL_TIMED_TRIG];

    // RULE_08: trigger source select
    always_comb begin
        unique case (pas_src_e'(s.src))
            SRC_START: dg_trig = run_rise;
            SRC_STOP: dg_trig = run_fall;
            SRC_BOTH: dg_trig = run_rise | run_fall;
            SRC_DIN: dg_trig = din_rise;
            SRC_SLC: dg_trig = slc_trig;
            SRC_TIMED: dg_trig = timed_trig;
            SRC_POWER: dg_trig = pwr_rise;
            default: dg_trig = 1'b0;
        endcase
    end

    // RULE_06: extended status word
    always_comb begin
        status = '0;
        status[STAT_RUN] = s.m_run;
        status[STAT_REV] = s.m_rev;
        status[STAT_COAST] = s.m_coast;
        status[STAT_LUBE] = s.lube;
        status[STAT_FLOW_VER] = s.fl_ver;
        status[STAT_TRIP] = s.trip;
        status[STAT_DERAG] = s.dg_act;
    end

    // Map is contiguous: every aligned word up to the alarm register exists
    assign mapped = (paddr <= REG_ALARM) & (paddr[1:0] == 2'h0);

    // Next state of the whole block
    always_comb begin
        next_s = s;
        // Two-flop synchronisers for the pins
        next_s.run_m = run_req;
        next_s.run_s = s.run_m;
        next_s.run_d = s.run_s;
        next_s.din_m = derag_din;
        next_s.din_s = s.din_m;
        next_s.din_d = s.din_s;
        next_s.flow_m = flow_ok;
        next_s.flow_s = s.flow_m;
        next_s.pwr_d = high_power;

        // Read data is latched in the setup cycle so it leaves a flop
        next_s.rdy = setup;
        next_s.err = setup & ~mapped;
        if (setup) begin
            unique case (paddr)
                REG_CTRL: next_s.rdata = {24'h000000, s.dout_dg, s.src, s.flow_en,
                                          s.dg_en, s.lube_mode};
                REG_DG_CYCLES: next_s.rdata = {24'h000000, s.dg_cycles};
                REG_DG_RUN: next_s.rdata = {16'h0000, s.dg_run};
                REG_DG_OFF: next_s.rdata = {16'h0000, s.dg_off};
                REG_START_DLY: next_s.rdata = {16'h0000, s.start_dly};
                REG_PRE_LUBE: next_s.rdata = {16'h0000, s.pre_lube};
                REG_POST_LUBE: next_s.rdata = {16'h0000, s.post_lube};
                REG_VALID: next_s.rdata = {16'h0000, s.valid_t};
                REG_VERIFY: next_s.rdata = {16'h0000, s.verify_t};
                REG_STATUS: next_s.rdata = status;
                REG_ALARM: next_s.rdata = {24'h000000, s.alarm};
                default: next_s.rdata = '0;
            endcase
        end

        // Register writes; an alarm write clears the trip, a new trip below wins
        if (wr) begin
            unique case (paddr)
                REG_CTRL: begin
                    next_s.lube_mode = pwdata[CTRL_LUBE_LO +: 2];
                    next_s.dg_en = pwdata[CTRL_DG_EN];
                    next_s.flow_en = pwdata[CTRL_FLOW_EN];
                    next_s.src = pwdata[CTRL_SRC_LO +: 3];
                    next_s.dout_dg = pwdata[CTRL_DOUT_DG];
                end
                REG_DG_CYCLES: next_s.dg_cycles = pwdata[7:0];
                REG_DG_RUN: next_s.dg_run = pwdata[15:0];
                REG_DG_OFF: next_s.dg_off = pwdata[15:0];
                REG_START_DLY: next_s.start_dly = pwdata[15:0];
                REG_PRE_LUBE: next_s.pre_lube = pwdata[15:0];
                REG_POST_LUBE: next_s.post_lube = pwdata[15:0];
                REG_VALID: next_s.valid_t = pwdata[15:0];
                REG_VERIFY: next_s.verify_t = pwdata[15:0];
                REG_ALARM: begin
                    next_s.trip = 1'b0;
                    next_s.alarm = '0;
                end
                default: next_s.trip = s.trip;
            endcase
        end

        // Main sequencer; all timers move only on the tick
        unique case (s.state)
            ST_IDLE: begin
                if (s.dg_en & dg_trig) begin
                    // RULE_02: stopped, no off-delay
                    next_s.state = ST_DG_REV;
                    next_s.cnt = s.dg_run;
                    next_s.dg_left = s.dg_cycles;
                end else if (run_rise) begin
                    // RULE_14: start delay begins
                    next_s.state = ST_DELAY;
                    next_s.cnt = s.start_dly;
                end
            end
            ST_DELAY: begin
                if (!s.run_s) begin
                    next_s.state = ST_IDLE;
                end else if (s.dg_en & dg_trig) begin
                    next_s.state = ST_DG_REV;
                    next_s.cnt = s.dg_run;
                    next_s.dg_left = s.dg_cycles;
                end else if (s.cnt == '0) begin
                    // RULE_14: ramp only after delay
                    next_s.state = ST_RUN;
                    // RULE_15: open validation window
                    next_s.fl = s.flow_en ? FL_VALID : FL_OFF;
                    next_s.fcnt = s.valid_t;
                end else if (tick) begin
                    next_s.cnt = s.cnt - TMR_ONE;
                end
            end
            ST_RUN: begin
                if (s.dg_en & dg_trig) begin
                    // RULE_01: ramp to stop first
                    next_s.state = ST_DG_STOP;
                    next_s.dg_left = s.dg_cycles;
                    next_s.fl = FL_OFF;
                end else if (!s.run_s) begin
                    next_s.state = ST_IDLE;
                    next_s.fl = FL_OFF;
                end else begin
                    unique case (s.fl)
                        FL_VALID: begin
                            if (s.flow_s) begin
                                next_s.fl = FL_VERIFY;
                                next_s.fcnt = s.verify_t;
                            end else if (s.fcnt == '0) begin
                                // RULE_19: no flow ever seen
                                next_s.state = ST_TRIP;
                                next_s.fl = FL_OFF;
                                next_s.trip = 1'b1;
                                next_s.alarm = ALARM_NO_FLOW;
                            end else if (tick) begin
                                next_s.fcnt = s.fcnt - TMR_ONE;
                            end
                        end
                        FL_VERIFY: begin
                            if (!s.flow_s) begin
                                // RULE_17: flow lost, trip
                                next_s.state = ST_TRIP;
                                next_s.fl = FL_OFF;
                                next_s.trip = 1'b1;
                                next_s.alarm = ALARM_NO_FLOW;
                            end else if (s.fcnt == '0) begin
                                // RULE_16: re-sampled, normal run
                                next_s.fl = FL_DONE;
                            end else if (tick) begin
                                next_s.fcnt = s.fcnt - TMR_ONE;
                            end
                        end
                        default: next_s.fl = s.fl;
                    endcase
                end
            end
            ST_DG_STOP: begin
                if (motor_stopped) begin
                    next_s.state = ST_DG_OFF;
                    next_s.cnt = s.dg_off;
                    next_s.dg_fwd = 1'b0;
                end
            end
            ST_DG_OFF: begin
                // RULE_05: coast between pulses
                if (s.cnt == '0) begin
                    next_s.state = s.dg_fwd ? ST_DG_FWD : ST_DG_REV;
                    next_s.cnt = s.dg_run;
                end else if (tick) begin
                    next_s.cnt = s.cnt - TMR_ONE;
                end
            end
            ST_DG_REV: begin
                // RULE_03: reverse pulse, then forward
                if (s.cnt == '0) begin
                    next_s.state = ST_DG_OFF;
                    next_s.cnt = s.dg_off;
                    next_s.dg_fwd = 1'b1;
                end else if (tick) begin
                    next_s.cnt = s.cnt - TMR_ONE;
                end
            end
            ST_DG_FWD: begin
                if (s.cnt != '0) begin
                    if (tick) begin
                        next_s.cnt = s.cnt - TMR_ONE;
                    end
                end else if (s.dg_left <= DEF_DG_CYCLES) begin
                    // RULE_04: last forward run-time done
                    next_s.state = s.run_s ? ST_RUN : ST_IDLE;
                    next_s.fl = FL_OFF;
                    next_s.dg_left = '0;
                end else begin
                    next_s.state = ST_DG_OFF;
                    next_s.cnt = s.dg_off;
                    next_s.dg_fwd = 1'b0;
                    next_s.dg_left = s.dg_left - DEF_DG_CYCLES;
                end
            end
            ST_TRIP: begin
                if (!next_s.trip & !s.run_s) begin
                    next_s.state = ST_IDLE;
                end
            end
            default: next_s.state = ST_IDLE;
        endcase

        // Lubrication output
        unique case (pas_lube_e'(s.lube_mode))
            LUBE_OFF: begin
                next_s.lube = 1'b0;
                next_s.post = 1'b0;
            end
            LUBE_PRE: begin
                next_s.post = 1'b0;
                if (run_rise) begin
                    // RULE_10: on at run rise
                    // RULE_12: pre time governs here
                    next_s.lube = 1'b1;
                    next_s.lcnt = s.pre_lube;
                end else if (s.lube & (s.lcnt == '0)) begin
                    next_s.lube = 1'b0;
                end else if (s.lube & tick) begin
                    next_s.lcnt = s.lcnt - TMR_ONE;
                end
            end
            default: begin
                // RULE_11: modes two and three
                if (run_rise | (next_s.state == ST_DELAY) | (next_s.state == ST_RUN)) begin
                    next_s.lube = 1'b1;
                    next_s.post = 1'b0;
                end else if (s.lube & !s.post) begin
                    if (s.lube_mode == LUBE_RUN) begin
                        next_s.lube = 1'b0;
                    end else if (motor_stopped) begin
                        // RULE_13: post hold after stop
                        next_s.post = 1'b1;
                        next_s.lcnt = s.post_lube;
                    end
                end else if (s.post) begin
                    if (s.lcnt == '0) begin
                        next_s.lube = 1'b0;
                        next_s.post = 1'b0;
                    end else if (tick) begin
                        next_s.lcnt = s.lcnt - TMR_ONE;
                    end
                end
            end
        endcase

        // Registered outputs follow the next state
        next_s.m_run = (next_s.state == ST_RUN) | (next_s.state == ST_DG_REV) |
                       (next_s.state == ST_DG_FWD);
        next_s.m_rev = next_s.state == ST_DG_REV;
        next_s.m_coast = next_s.state == ST_DG_OFF;
        next_s.dg_act = (next_s.state == ST_DG_STOP) | (next_s.state == ST_DG_OFF) |
                        (next_s.state == ST_DG_REV) | (next_s.state == ST_DG_FWD);
        // RULE_07: output mirrors cleaning
        next_s.dg_dout = next_s.dg_act & next_s.dout_dg;
        // RULE_18: verifying status
        next_s.fl_ver = (next_s.fl == FL_VALID) | (next_s.fl == FL_VERIFY);
    end

    // RULE_20: timers reset with system
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.state <= ST_IDLE;
            s.fl <= FL_OFF;
            s.pre_lube <= DEF_PRE_LUBE;
            s.post_lube <= DEF_POST_LUBE;
            s.valid_t <= DEF_VALID;
            s.verify_t <= DEF_VERIFY;
            s.dg_run <= DEF_DG_RUN;
            s.dg_off <= DEF_DG_OFF;
            s.dg_cycles <= DEF_DG_CYCLES;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Ports come straight from the state flops
    assign prdata = s.rdata;
    assign pready = s.rdy;
    assign pslverr = s.err;
    assign motor_run = s.m_run;
    assign motor_rev = s.m_rev;
    assign motor_coast = s.m_coast;
    assign lube_out = s.lube;
    assign derag_dout = s.dg_dout;
    assign derag_active = s.dg_act;
    assign flow_verifying = s.fl_ver;
    assign no_flow_trip = s.trip;
    assign alarm_code = s.alarm;

endmodule : pas_seq

`default_nettype wire

// File: logic/pas_pkg.sv
// Constants, register map and state encodings for the pump start sequencer
// Overview of operation
// RULE_01: Running motor: stop, off-delay, then first cycle
// RULE_02: Stopped motor: skip off-delay, start cycle at once
// RULE_03: Cycle is reverse pulse then forward pulse
// RULE_04: Done after last forward pulse full run-time
// RULE_05: Motor coasts for off-delay between pulses
// RULE_06: Status bit 23 set while cleaning active
// RULE_07: Digital output can mirror cleaning active
// RULE_08: Selectable cleaning trigger sources
// RULE_09: Enable cleaning only for reversible pumps
// RULE_10: Lube output on at run request rise
// RULE_11: Lube modes off, pre, running, post
// RULE_12: Pre-lube time used only in pre mode
// RULE_13: Post-lube hold after motor stopped, mode three
// RULE_14: Start delay and pre-lube start together
// RULE_15: Run motor, wait validation time for flow
// RULE_16: Re-sample flow after verification time, then run
// RULE_17: Flow lost during check trips, alarm 92
// RULE_18: Flow-verifying status during flow check
// RULE_19: Validation timeout without flow trips too
// RULE_20: Timers count common 0.1 s tick, reset
`default_nettype none

package pas_pkg;

    // Clock and tick timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_PERIOD_NS = 100_000_000;
    localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef logic [15:0] pas_tmr_t;
    localparam pas_tmr_t TMR_ONE = 16'h0001;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DG_CYCLES = 8'h04;
    localparam logic [7:0] REG_DG_RUN = 8'h08;
    localparam logic [7:0] REG_DG_OFF = 8'h0c;
    localparam logic [7:0] REG_START_DLY = 8'h10;
    localparam logic [7:0] REG_PRE_LUBE = 8'h14;
    localparam logic [7:0] REG_POST_LUBE = 8'h18;
    localparam logic [7:0] REG_VALID = 8'h1c;
    localparam logic [7:0] REG_VERIFY = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_ALARM = 8'h28;

    // Control register fields
    localparam int CTRL_LUBE_LO = 0;
    localparam int CTRL_DG_EN = 2;
    localparam int CTRL_FLOW_EN = 3;
    localparam int CTRL_SRC_LO = 4;
    localparam int CTRL_DOUT_DG = 7;
    localparam int CTRL_SLC_TRIG = 8;
    localparam int CTRL_TIMED_TRIG = 9;

    // Status word fields
    localparam int STAT_RUN = 0;
    localparam int STAT_REV = 1;
    localparam int STAT_COAST = 2;
    localparam int STAT_LUBE = 3;
    localparam int STAT_FLOW_VER = 4;
    localparam int STAT_TRIP = 5;
    localparam int STAT_DERAG = 23;

    // Reset values of settings, in ticks except the cleaning cycle count
    localparam pas_tmr_t DEF_PRE_LUBE = 16'h0064;
    localparam pas_tmr_t DEF_POST_LUBE = 16'h0064;
    localparam pas_tmr_t DEF_VERIFY = 16'h0096;
    localparam pas_tmr_t DEF_VALID = 16'h0064;
    localparam pas_tmr_t DEF_DG_RUN = 16'h0032;
    localparam pas_tmr_t DEF_DG_OFF = 16'h0032;
    localparam logic [7:0] DEF_DG_CYCLES = 8'h01;

    localparam logic [7:0] ALARM_NO_FLOW = 8'h5c;

    typedef enum logic [1:0] {
        LUBE_OFF = 2'h0,
        LUBE_PRE = 2'h1,
        LUBE_RUN = 2'h2,
        LUBE_POST = 2'h3
    } pas_lube_e;

    typedef enum logic [2:0] {
        SRC_START = 3'h0,
        SRC_STOP = 3'h1,
        SRC_BOTH = 3'h2,
        SRC_DIN = 3'h3,
        SRC_SLC = 3'h4,
        SRC_TIMED = 3'h5,
        SRC_POWER = 3'h6
    } pas_src_e;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DELAY = 8'h02,
        ST_RUN = 8'h04,
        ST_DG_STOP = 8'h08,
        ST_DG_OFF = 8'h10,
        ST_DG_REV = 8'h20,
        ST_DG_FWD = 8'h40,
        ST_TRIP = 8'h80
    } pas_state_e;

    typedef enum logic [3:0] {
        FL_OFF = 4'h1,
        FL_VALID = 4'h2,
        FL_VERIFY = 4'h4,
        FL_DONE = 4'h8
    } pas_flow_e;

endpackage : pas_pkg

`default_nettype wire

// File: logic/pas_tick.sv
// Divider that makes the common 0.1 s timer tick
`default_nettype none

module pas_tick import pas_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic ce, // Clock enable
    output logic tick // One-cycle pulse per tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } pas_tick_s;

    pas_tick_s s;
    pas_tick_s next_s;

    localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

    // Free-running count, one pulse when it wraps
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt >= LAST) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 32'h00000001;
        end
    end

    // RULE_20: tick reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule : pas_tick

`default_nettype wire

// File: bench/pas_checker.sv
// Port assertions for the pump start sequencer
`default_nettype none
module pas_checker import pas_pkg::*; (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic run_req, // Run pin
    input wire logic motor_run, // Drive
    input wire logic motor_rev, // Reverse
    input wire logic motor_coast, // Coast
    input wire logic lube_out, // Lube request
    input wire logic derag_dout, // Cleaning mirror
    input wire logic derag_active, // Cleaning event
    input wire logic flow_verifying, // Flow check
    input wire logic no_flow_trip, // Trip
    input wire logic [7:0] alarm_code // Alarm number
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A reverse pulse may only open inside a cleaning event
    sequence s_rev_start;
        $rose(motor_rev);
    endsequence
    sequence s_event_end;
        $fell(derag_active);
    endsequence
    AST_REV_ACT: assert property (s_rev_start |-> derag_active)
        else $error("reverse pulse outside cleaning");
    AST_REV_RUN: assert property (motor_rev |-> motor_run)
        else $error("reverse without drive");
    AST_COAST: assert property (motor_coast |-> !motor_run && !motor_rev)
        else $error("coast while driving");
    AST_DOUT: assert property (derag_dout |-> derag_active)
        else $error("mirror without cleaning");
    // Event closes only after a forward pulse, never straight from reverse
    AST_DG_END: assert property (s_event_end |-> $past(motor_run) && !$past(motor_rev))
        else $error("cleaning ended off a forward pulse");
    AST_ALARM: assert property (no_flow_trip |-> alarm_code == ALARM_NO_FLOW)
        else $error("trip without no-flow alarm");
    AST_TRIP: assert property (no_flow_trip |-> !motor_run)
        else $error("motor driven while tripped");
    AST_FLOW: assert property (flow_verifying |-> motor_run)
        else $error("flow check with motor off");
    // Pin passes two sync flops, so the request is already old when lube starts
    AST_LUBE: assert property ($rose(lube_out) |-> $past(run_req, 2))
        else $error("lube rose without run request");
endmodule : pas_checker
bind pas_seq pas_checker chk_u (.*);
`default_nettype wire

// File: bench/pas_motor.sv
// Motor power stage model: slows to standstill after the drive is released
`default_nettype none
module pas_motor (
    input wire logic clk, // Clock
    input wire logic motor_run, // Drive request
    output logic motor_stopped // Standstill flag
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned ramp = 0;
    // ramp to stop: standstill comes late, so the stop wait is real
    always_ff @(posedge clk) begin
        ramp <= motor_run ? 0 : (ramp < 12 ? ramp + 1 : ramp);
    end
    assign motor_stopped = !motor_run && ramp >= 12;
endmodule : pas_motor
`default_nettype wire

// File: bench/pas_seq_bench.sv
// Self-checking bench: registers, lubrication, cleaning and flow check
`default_nettype none
module pas_seq_bench import pas_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, run_req = 0, derag_din = 0, flow_ok = 0, high_power = 0;
    logic motor_stopped, motor_run, motor_rev, motor_coast, lube_out;
    logic derag_dout, derag_active, flow_verifying, no_flow_trip;
    logic [7:0] alarm_code;
    int err_total = 0, n_compared = 0, n;
    pas_seq #(.TICK_CYCLES(10)) dut_u (.*);
    pas_motor mot_u (.*);
    // Clock, 5 ns period
    initial forever #2.5 clk = ~clk;
    task stop_test();
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // Bounded wait for a level; cycles waited come back for timing checks
    task automatic wt(ref logic s, input logic v, output int c);
        for (c = 0; c < 3000 && s !== v; c++) @(posedge clk);
        if (c == 3000) begin
            err_total++;
            stop_test();
        end
    endtask : wt
    // One APB transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        for (k = 0; k < 9 && pready !== 1'b1; k++) @(posedge clk);
        rd = prdata;
        chk(pready, 1);
        if (pready !== 1'b1) stop_test();
        {psel, penable} <= 2'b00;
    endtask : apb
    task t_regs();
        apb(0, REG_VERIFY, 0);
        chk(rd, 32'h96);
        apb(0, 8'h2c, 0);
        chk(pslverr, 1);
    endtask : t_regs
    task t_lube();
        apb(1, REG_PRE_LUBE, 3);
        apb(1, REG_START_DLY, 2);
        apb(1, REG_CTRL, 1);
        run_req <= 1;
        wt(lube_out, 1, n);
        wt(motor_run, 1, n);
        chk(n >= 12 && n <= 21, 1);
        chk(lube_out, 1);
        wt(lube_out, 0, n);
        chk(n <= 12, 1);
        run_req <= 0;
        apb(1, REG_START_DLY, 0);
        apb(1, REG_CTRL, 3);
        run_req <= 1;
        wt(motor_run, 1, n);
        run_req <= 0;
        wt(lube_out, 0, n);
        chk(n >= 1009 && n <= 1018, 1);
    endtask : t_lube
    // Cleaning of two cycles, from standstill or from running
    task t_derag(input logic [31:0] ctl, input logic running);
        int cnt;
        logic prev;
        apb(1, REG_DG_CYCLES, 2);
        apb(1, REG_DG_RUN, 2);
        apb(1, REG_DG_OFF, 2);
        apb(1, REG_CTRL, ctl);
        run_req <= 1;
        if (running) begin
            wt(motor_run, 1, n);
            apb(1, REG_CTRL, ctl | 32'h100);
            derag_din <= 1; // Pin trigger for the input source
        end
        wt(derag_active, 1, n);
        wt(motor_rev, 1, n);
        chk(n < 20, !running);
        apb(0, REG_STATUS, 0);
        chk(rd[STAT_DERAG], 1);
        chk(derag_dout, 1);
        cnt = 0;
        prev = 0;
        for (n = 0; n < 3000 && derag_active === 1'b1; n++) begin
            @(posedge clk);
            if (motor_rev === 1'b1 && !prev) cnt++;
            prev = motor_rev;
        end
        chk(n < 3000, 1);
        if (n == 3000) stop_test();
        chk(cnt, 2);
        chk(derag_dout, 0);
        {run_req, derag_din} <= 2'b00;
        repeat (20) @(posedge clk);
    endtask : t_derag
    // Flow check: missing flow, good flow, flow lost in verification
    task t_flow();
        apb(1, REG_CTRL, 32'h08);
        apb(1, REG_VALID, 3);
        apb(1, REG_VERIFY, 2);
        run_req <= 1;
        wt(flow_verifying, 1, n);
        wt(no_flow_trip, 1, n);
        chk(n >= 22 && n <= 31, 1);
        apb(0, REG_ALARM, 0);
        chk(rd, 32'h5c);
        run_req <= 0;
        apb(1, REG_ALARM, 0);
        flow_ok <= 1;
        run_req <= 1;
        wt(flow_verifying, 1, n);
        wt(flow_verifying, 0, n);
        chk({no_flow_trip, motor_run}, 1);
        run_req <= 0;
        repeat (20) @(posedge clk);
        run_req <= 1;
        wt(flow_verifying, 1, n);
        repeat (8) @(posedge clk);
        flow_ok <= 0;
        wt(no_flow_trip, 1, n);
        chk(alarm_code, 8'h5c);
    endtask : t_flow
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        t_regs();
        t_lube();
        t_derag(32'h84, 0);
        t_derag(32'hc4, 1);
        t_derag(32'hb4, 1);
        t_flow();
        stop_test();
    end
endmodule : pas_seq_bench
`default_nettype wire
